/* bmrc_top.sv */
// Boot mode selection and system reset control with debug remap and shared trace pin.
// Assumes APB master on CLK_SYS_I; strap, external reset and debug-attach pins are async.
`timescale 1ns/1ps
module bmrc_top
    import bmrc_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = bmrc_pkg::RST_HOLD_CYC
) (
    input wire logic CLK_SYS_I,                        // System clock, 25 MHz
    input wire logic RST_I,                            // Power-on reset, async, active high
    input wire logic BOOT_STRAP_PRIMARY_I,             // Primary boot strap pin
    input wire logic BOOT_STRAP_SECONDARY_I,           // Secondary boot strap pin
    input wire logic EXT_RESET_N_I,                    // External reset pin, active low
    input wire logic DEBUG_SESSION_I,                  // Debugger attached, async level
    input wire logic TEST_DATA_OUT_ROLE_I,             // JTAG data out from the TAP
    input wire logic TEST_DATA_OUT_OE_I,               // TAP drives data out
    input wire logic SERIAL_TRACE_OUTPUT_I,            // Serial trace data
    input wire logic PSEL_I,                           // APB select
    input wire logic PENABLE_I,                        // APB enable
    input wire logic PWRITE_I,                         // APB write
    input wire logic [bmrc_pkg::APB_AW-1:0] PADDR_I,   // APB byte address
    input wire logic [31:0] PWDATA_I,                  // APB write data
    output logic [31:0] PRDATA_O,                      // APB read data
    output logic PREADY_O,                             // APB ready
    output logic PSLVERR_O,                            // APB error, unmapped address
    output bmrc_pkg::bmrc_boot_t BOOT_REGION_O,        // Latched fetch region
    output logic SYS_RESET_O,                          // System reset, active high
    output logic JTAG_EN_O,                            // JTAG port enabled
    output logic TRST_PIN_EN_O,                        // Test reset pin owned by JTAG
    output logic SHARED_PIN_O,                         // Shared data-out/trace pin value
    output logic SHARED_PIN_OE_O                       // Shared pin output enable
);
    import bmrc_pkg::*;

    localparam int unsigned CNT_MAX = (HOLD_CYCLES > SETTLE_CYC) ? HOLD_CYCLES : SETTLE_CYC;
    localparam int CW = $clog2(CNT_MAX + 1);
    localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD_CYCLES - 1);
    localparam logic [CW-1:0] SETTLE_LOAD = CW'(SETTLE_CYC - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    // Synchronised pins
    logic [3:0] sync_bus;
    bmrc_strap_t strap_s;
    logic ext_rst_n_s;
    logic dbg_s;

    bmrc_sync #(
        .WIDTH(4),
        .RST_VAL(SYNC_RST_VAL)
    ) u_sync (
        .CLK_SYS_I(CLK_SYS_I),
        .RST_I(RST_I),
        .ASYNC_I({DEBUG_SESSION_I, EXT_RESET_N_I, BOOT_STRAP_SECONDARY_I,
                  BOOT_STRAP_PRIMARY_I}),
        .SYNC_O(sync_bus)
    );

    assign strap_s = bmrc_strap_t'(sync_bus[1:0]);
    assign ext_rst_n_s = sync_bus[2];
    assign dbg_s = sync_bus[3];

    // State
    bmrc_state_t state_r;
    bmrc_state_t state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    bmrc_cause_t cause_r;
    bmrc_cause_t cause_nxt;
    bmrc_boot_t boot_r;
    bmrc_boot_t boot_nxt;
    bmrc_remap_t remap_r;
    bmrc_remap_t remap_nxt;
    logic sys_rst_r;
    logic pin_r;
    logic pin_oe_r;
    logic [31:0] prdata_r;
    logic sample_en;

    // APB decode
    wire setup_ph = PSEL_I & ~PENABLE_I;
    wire access_ph = PSEL_I & PENABLE_I;
    wire wr_en = access_ph & PWRITE_I;
    wire hit_ctrl = (PADDR_I == OFS_CTRL);
    wire hit_remap = (PADDR_I == OFS_REMAP);
    wire hit_status = (PADDR_I == OFS_STATUS);
    wire unmapped = ~(hit_ctrl | hit_remap | hit_status);
    wire in_run = (state_r == ST_RUN);

    // Writes land only while the system runs; during a reset hold they are dropped
    wire ctrl_wr = wr_en & hit_ctrl & in_run;
    wire remap_wr = wr_en & hit_remap & in_run;
    wire sw_req = ctrl_wr & PWDATA_I[CTRL_SWRST_BIT];
    wire prot_req = ctrl_wr & PWDATA_I[CTRL_PROT_BIT];
    wire bmrc_remap_t remap_wdata = bmrc_remap_t'(PWDATA_I[2:0]);
    wire debug_cut = remap_wdata.jtag_off | remap_wdata.trst_free;
    wire dbg_trip = remap_wr & dbg_s & debug_cut;
    wire ext_act = ~ext_rst_n_s;
    wire jtag_on = ~remap_r.jtag_off;

    // Reset sequencing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        cause_nxt = cause_r;
        sample_en = 1'b0;
        case (state_r)
            ST_SETTLE: begin
                // Wait for the synchronisers to carry real pin levels
                if (cnt_r == CNT_ZERO) begin
                    sample_en = 1'b1;
                    state_nxt = ST_RUN;
                end else begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end
            end
            ST_RUN: begin
                if (ext_act) begin
                    state_nxt = ST_HOLD;
                    cause_nxt = CAUSE_EXT;
                    cnt_nxt = HOLD_LOAD;
                end else if (dbg_trip) begin
                    state_nxt = ST_HOLD;
                    cause_nxt = CAUSE_DBG;
                    cnt_nxt = HOLD_LOAD;
                end else if (prot_req) begin
                    state_nxt = ST_HOLD;
                    cause_nxt = CAUSE_PROT;
                    cnt_nxt = HOLD_LOAD;
                end else if (sw_req) begin
                    state_nxt = ST_HOLD;
                    cause_nxt = CAUSE_SW;
                    cnt_nxt = HOLD_LOAD;
                end
            end
            ST_HOLD: begin
                if (ext_act) begin
                    // Pin held low keeps the system in reset and turns it external
                    cause_nxt = CAUSE_EXT;
                    cnt_nxt = HOLD_LOAD;
                end else if (cnt_r == CNT_ZERO) begin
                    state_nxt = ST_RELEASE;
                end else begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end
            end
            ST_RELEASE: begin
                // Soft, protection and debug resets skip the strap resample
                sample_en = (cause_r == CAUSE_EXT);
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_SETTLE;
                cnt_nxt = SETTLE_LOAD;
            end
        endcase
    end

    assign boot_nxt = sample_en ? bmrc_decode(strap_s) : boot_r;

    // A trip never applies the remap: the reset clears it first
    assign remap_nxt = (state_nxt != ST_RUN) ? REMAP_RESET :
                       remap_wr ? remap_wdata : remap_r;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            state_r <= ST_SETTLE;
            cnt_r <= SETTLE_LOAD;
            cause_r <= CAUSE_POR;
            sys_rst_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            cause_r <= cause_nxt;
            sys_rst_r <= (state_nxt != ST_RUN);
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            boot_r <= BOOT_USER_FLASH;
            remap_r <= REMAP_RESET;
        end else begin
            boot_r <= boot_nxt;
            remap_r <= remap_nxt;
        end
    end

    // Shared pin: JTAG data out wins until the port is remapped off
    wire pin_nxt = jtag_on ? TEST_DATA_OUT_ROLE_I : SERIAL_TRACE_OUTPUT_I;
    wire pin_oe_nxt = jtag_on ? TEST_DATA_OUT_OE_I : remap_r.trace_en;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            pin_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    // Read data captured in the setup phase so the access phase shows a flop
    logic [31:0] status_word;
    always_comb begin
        status_word = RD_ZERO;
        status_word[STAT_BOOT_LSB +: 2] = boot_r;
        status_word[STAT_CAUSE_LSB +: 3] = cause_r;
        status_word[STAT_DBG_BIT] = dbg_s;
        status_word[STAT_TRACE_BIT] = ~jtag_on & remap_r.trace_en;
        status_word[STAT_HOLD_BIT] = sys_rst_r;
    end

    wire [31:0] remap_word = {29'h0000_0000, remap_r};
    wire [31:0] rd_mux = hit_remap ? remap_word :
                         hit_status ? status_word : RD_ZERO;

    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            prdata_r <= RD_ZERO;
        end else if (setup_ph & ~PWRITE_I) begin
            prdata_r <= rd_mux;
        end
    end

    assign PRDATA_O = prdata_r;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = access_ph & unmapped;
    assign BOOT_REGION_O = boot_r;
    assign SYS_RESET_O = sys_rst_r;
    assign JTAG_EN_O = jtag_on;
    assign TRST_PIN_EN_O = ~remap_r.trst_free;
    assign SHARED_PIN_O = pin_r;
    assign SHARED_PIN_OE_O = pin_oe_r;

    // Checks
    boot_decode_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        sample_en |=> (boot_r == bmrc_decode($past(strap_s))))
        else $error("boot region does not match strap decode");

    sw_keep_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (state_r inside {ST_HOLD, ST_RELEASE}) && (cause_r == CAUSE_SW) |=> $stable(boot_r))
        else $error("software reset changed boot region");

    prot_reset_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (in_run && prot_req && !ext_act && !dbg_trip)
        |=> SYS_RESET_O && (cause_r == CAUSE_PROT) ##1 SYS_RESET_O)
        else $error("protection enable did not start a reset");

    prot_keep_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (state_r == ST_RELEASE) && (cause_r == CAUSE_PROT) |-> !sample_en ##1 $stable(boot_r))
        else $error("protection reset resampled straps");

    ext_resample_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (state_r == ST_RELEASE) && (cause_r == CAUSE_EXT)
        |=> (boot_r == bmrc_decode($past(strap_s))))
        else $error("external reset did not resample straps");

    dbg_reset_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        dbg_trip |=> SYS_RESET_O && !remap_r.jtag_off && !remap_r.trst_free)
        else $error("debug remap did not reset at once");

    nodbg_apply_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (remap_wr && !dbg_s && !ext_act)
        |=> !SYS_RESET_O && (remap_r == $past(remap_wdata)))
        else $error("remap without debugger misapplied");

    tdo_prio_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        jtag_on |=> (SHARED_PIN_O == $past(TEST_DATA_OUT_ROLE_I)))
        else $error("shared pin not carrying JTAG data out");

    trace_route_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (!jtag_on && remap_r.trace_en)
        |=> SHARED_PIN_OE_O && (SHARED_PIN_O == $past(SERIAL_TRACE_OUTPUT_I)))
        else $error("trace not routed after JTAG disable");

    latch_only_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !sample_en |=> $stable(boot_r))
        else $error("boot latch changed without a sample");

    hold_len_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        (in_run && (state_nxt == ST_HOLD)) |=> SYS_RESET_O [*8])
        else $error("system reset pulse too short");

endmodule

/* bmrc_pkg.sv */
// Constants, types and the strap decode for the boot mode and reset control block.
// Assumes one 25 MHz system clock and a 32-bit APB register port.
// Operation
// - Boot region from straps: primary low is user flash, else secondary picks memory.
// - Software system reset keeps the latched boot region; straps are not resampled.
// - Enabling loader protection starts a self system reset keeping the boot region.
// - New strap settings apply only after external reset or power cycle.
// - With a debugger attached, disabling JTAG or freeing test reset resets at once.
// - Without a debugger, those remap settings simply take effect with no reset.
// - Shared pin gives JTAG data out priority; trace only after JTAG disabled.
package bmrc_pkg;

    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned RST_HOLD_NS = 640;
    localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_CYC = 3;

    localparam int APB_AW = 12;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_REMAP = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;

    localparam int CTRL_SWRST_BIT = 0;
    localparam int CTRL_PROT_BIT = 1;
    localparam int STAT_BOOT_LSB = 0;
    localparam int STAT_CAUSE_LSB = 4;
    localparam int STAT_DBG_BIT = 8;
    localparam int STAT_TRACE_BIT = 9;
    localparam int STAT_HOLD_BIT = 10;

    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // Sync reset values: ext reset pin idles high (inactive)
    localparam logic [3:0] SYNC_RST_VAL = 4'h4;

    typedef enum logic [1:0] {
        BOOT_USER_FLASH = 2'h0,
        BOOT_SYSTEM_MEM = 2'h1,
        BOOT_SRAM = 2'h3
    } bmrc_boot_t;

    typedef enum logic [2:0] {
        CAUSE_POR = 3'h0,
        CAUSE_EXT = 3'h1,
        CAUSE_SW = 3'h2,
        CAUSE_PROT = 3'h3,
        CAUSE_DBG = 3'h4
    } bmrc_cause_t;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'h0,
        ST_RUN = 2'h1,
        ST_HOLD = 2'h3,
        ST_RELEASE = 2'h2
    } bmrc_state_t;

    typedef struct packed {
        logic boot_strap_secondary;
        logic boot_strap_primary;
    } bmrc_strap_t;

    // Remap layout: bit0 jtag_off, bit1 trst_free, bit2 trace_en
    typedef struct packed {
        logic trace_en;
        logic trst_free;
        logic jtag_off;
    } bmrc_remap_t;

    localparam bmrc_remap_t REMAP_RESET = 3'h0;

    function automatic bmrc_boot_t bmrc_decode(input bmrc_strap_t s);
        bmrc_boot_t b;
        if (!s.boot_strap_primary) begin
            b = BOOT_USER_FLASH;
        end else if (!s.boot_strap_secondary) begin
            b = BOOT_SYSTEM_MEM;
        end else begin
            b = BOOT_SRAM;
        end
        return b;
    endfunction

endpackage

/* bmrc_sync.sv */
// Two-flop synchroniser, one stage pair per bit.
// Assumes inputs are asynchronous to CLK_SYS_I; reset values are constants.
`timescale 1ns/1ps
module bmrc_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic CLK_SYS_I,          // System clock
    input wire logic RST_I,              // Async reset, active high
    input wire logic [WIDTH-1:0] ASYNC_I, // Raw inputs
    output logic [WIDTH-1:0] SYNC_O      // Synchronised outputs
);
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_r;
        logic sync_r;
        always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
            if (RST_I) begin
                meta_r <= RST_VAL[i];
                sync_r <= RST_VAL[i];
            end else begin
                meta_r <= ASYNC_I[i];
                sync_r <= meta_r;
            end
        end
        assign SYNC_O[i] = sync_r;
    end
endmodule

/* bmrc_board.sv */
// Board-side partner: strap pins, external reset button, debug probe and TAP.
// Assumes the bench sets the wanted strap, reset and probe levels on its inputs.
`timescale 1ns/1ps
module bmrc_board (
    input wire logic clk_i,          // System clock
    input wire logic [1:0] strap_i,  // Wanted straps, bit0 primary
    input wire logic ext_req_i,      // Hold external reset
    input wire logic dbg_req_i,      // Probe attached
    output logic prim_o,             // Primary strap pin
    output logic sec_o,              // Secondary strap pin
    output logic ext_n_o,            // External reset pin, active low
    output logic dbg_o,              // Debug session level
    output logic tdo_o,              // TAP data out
    output logic tdo_oe_o,           // TAP output enable
    output logic trace_o             // Serial trace data
);
    // Straps only count after power-on reset or after the bench pulses the reset pin
    assign prim_o = strap_i[0];
    assign sec_o = strap_i[1];
    assign ext_n_o = ~ext_req_i;
    assign dbg_o = dbg_req_i;
    // New data every cycle so a stale route cannot pass
    initial begin
        tdo_o = 1'b0;
        tdo_oe_o = 1'b0;
        trace_o = 1'b0;
    end
    always @(posedge clk_i) begin
        tdo_o <= 1'($urandom);
        tdo_oe_o <= 1'($urandom);
        trace_o <= 1'($urandom);
    end
endmodule

/* bmrc_top_tb.sv */
// Self-checking bench for the boot mode and reset control block.
// Assumes the board partner drives straps, reset pin, probe and TAP lines.
`timescale 1ns/1ps
module bmrc_top_tb;
    import bmrc_pkg::*;
    localparam int HOLD = 8;
    logic clk, rst, psel, penable, pwrite, ext_req, dbg_req, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, sys_rst, jtag_en, trst_en, pin, pin_oe;
    logic prim, sec, ext_n, dbg, tdo, tdo_oe, trace;
    logic [1:0] strap, e2;
    logic [2:0] v;
    logic [2:0] tbl [0:4] = '{3'h7, 3'h3, 3'h4, 3'h0, 3'h1};
    bmrc_boot_t region;
    int err_total, tests_run, boot_m, cause_m, len;

    bmrc_board board_u (.clk_i(clk), .strap_i(strap), .ext_req_i(ext_req), .dbg_req_i(dbg_req),
        .prim_o(prim), .sec_o(sec), .ext_n_o(ext_n), .dbg_o(dbg), .tdo_o(tdo),
        .tdo_oe_o(tdo_oe), .trace_o(trace));
    bmrc_top #(.HOLD_CYCLES(HOLD)) dut_u (.CLK_SYS_I(clk), .RST_I(rst),
        .BOOT_STRAP_PRIMARY_I(prim), .BOOT_STRAP_SECONDARY_I(sec), .EXT_RESET_N_I(ext_n),
        .DEBUG_SESSION_I(dbg), .TEST_DATA_OUT_ROLE_I(tdo), .TEST_DATA_OUT_OE_I(tdo_oe),
        .SERIAL_TRACE_OUTPUT_I(trace), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .BOOT_REGION_O(region), .SYS_RESET_O(sys_rst),
        .JTAG_EN_O(jtag_en), .TRST_PIN_EN_O(trst_en), .SHARED_PIN_O(pin),
        .SHARED_PIN_OE_O(pin_oe));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task final_report;
        $display("Comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_pin(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic int boot_of(input logic [1:0] s);
        if (!s[0]) return 0;
        if (!s[1]) return 1;
        return 3;
    endfunction

    // Wait for pready at the access edge; no fixed latency assumed
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_rst;
        int n;
        len = 0;
        n = 0;
        while (n < 300) begin
            @(negedge clk);
            n++;
            if (sys_rst === 1'b1) len++;
            else if (len > 0) break;
        end
        if (n >= 300) err_total++;
    endtask

    task status_chk;
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk_reg(rd, 32'(boot_m | (cause_m << 4) | (int'(dbg_req) << 8)));
        chk_reg(32'(region), 32'(boot_m));
    endtask

    task ext_rst(input logic [1:0] s);
        @(posedge clk);
        strap <= s;
        repeat (3) @(posedge clk);
        ext_req <= 1'b1;
        repeat (4) @(posedge clk);
        ext_req <= 1'b0;
        wait_rst;
        boot_m = boot_of(s);
        cause_m = CAUSE_EXT;
    endtask

    // Straps are moved first: a resample would show in the region
    task sw_rst(input int b, input int c);
        @(posedge clk);
        strap <= (boot_m == 0) ? 2'h3 : 2'h0;
        repeat (3) @(posedge clk);
        apb(1'b1, OFS_CTRL, 32'(1 << b));
        wait_rst;
        chk_reg(32'(len), 32'(HOLD + 1));
        cause_m = c;
        status_chk;
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ext_req = 1'b0;
        dbg_req = 1'b0;
        err_total = 0;
        tests_run = 0;
        strap = 2'($urandom(32'hf34a));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wait_rst;
        boot_m = boot_of(strap);
        cause_m = CAUSE_POR;
        status_chk;
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk_reg(rd, 32'h0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk_reg({rd[30:0], er}, 32'h0000_0001);
        apb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
        chk_reg(32'(er), 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            ext_rst(2'(i));
            status_chk;
        end
        sw_rst(CTRL_SWRST_BIT, CAUSE_SW);
        sw_rst(CTRL_PROT_BIT, CAUSE_PROT);
        dbg_req <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 1; i < 4; i++) begin
            apb(1'b1, OFS_REMAP, {29'($urandom), 3'(i)});
            wait_rst;
            chk_reg(32'(len), 32'(HOLD + 1));
            cause_m = CAUSE_DBG;
            status_chk;
            apb(1'b0, OFS_REMAP, 32'h0000_0000);
            chk_reg(rd & 32'h0000_0007, 32'h0000_0000);
            chk_pin({jtag_en, trst_en}, 2'h3);
        end
        dbg_req <= 1'b0;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 5; k++) begin
            v = tbl[k];
            apb(1'b1, OFS_REMAP, {29'($urandom), v});
            repeat (4) @(posedge clk);
            chk_pin({sys_rst, 1'b0}, 2'h0);
            chk_pin({jtag_en, trst_en}, {~v[0], ~v[1]});
            apb(1'b0, OFS_REMAP, 32'h0000_0000);
            chk_reg(rd & 32'h0000_0007, 32'(v));
            apb(1'b0, OFS_STATUS, 32'h0000_0000);
            chk_reg(rd & 32'h0000_0600, 32'(v[0] & v[2]) << 9);
            repeat (8) begin
                @(negedge clk);
                e2 = v[0] ? {trace, v[2]} : {tdo, tdo_oe};
                @(posedge clk);
                #1;
                chk_pin({pin, pin_oe}, e2);
            end
        end
        ext_rst(2'h2);
        chk_pin({jtag_en, trst_en}, 2'h3);
        status_chk;
        final_report;
    end

    // Run needs a few hundred cycles; this allows about 50000
    initial begin
        #2000000;
        err_total++;
        final_report;
    end
endmodule
